// ---- rtl/ldce_pkg.sv ----
// Constants, register map and helper functions of the differential characteristic evaluator
package ldce_pkg;

   // Data widths
   localparam int MAG_W = 16;
   localparam int SET_W = 11;
   localparam int THR_W = 32;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int FLAG_N = 6;

   // Settings are percentages; thresholds are kept scaled by this factor
   localparam logic [THR_W-1:0] PCT_SCALE = 32'h0000_0064;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_BASE = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_SLOPE1 = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_SLOPE2 = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_BREAKPOINT = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_UNRESTRAINED = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_START = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h018;
   localparam logic [ADDR_W-1:0] OFS_CLEAR = 12'h01C;
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 12'h020;
   localparam logic [ADDR_W-1:0] OFS_BIAS = 12'h024;

   // Setting ranges and reset defaults
   localparam logic [DATA_W-1:0] BASE_MIN = 32'h0000_000A;
   localparam logic [DATA_W-1:0] BASE_MAX = 32'h0000_0032;
   localparam logic [SET_W-1:0] BASE_DEF = 11'h01E;
   localparam logic [DATA_W-1:0] SLOPE1_MIN = 32'h0000_000A;
   localparam logic [DATA_W-1:0] SLOPE1_MAX = 32'h0000_0032;
   localparam logic [SET_W-1:0] SLOPE1_DEF = 11'h01E;
   localparam logic [DATA_W-1:0] SLOPE2_MIN = 32'h0000_0032;
   localparam logic [DATA_W-1:0] SLOPE2_MAX = 32'h0000_0064;
   localparam logic [SET_W-1:0] SLOPE2_DEF = 11'h046;
   localparam logic [DATA_W-1:0] BREAKPOINT_MIN = 32'h0000_0064;
   localparam logic [DATA_W-1:0] BREAKPOINT_MAX = 32'h0000_0190;
   localparam logic [SET_W-1:0] BREAKPOINT_DEF = 11'h0C8;
   localparam logic [DATA_W-1:0] UNRESTRAINED_MIN = 32'h0000_01F4;
   localparam logic [DATA_W-1:0] UNRESTRAINED_MAX = 32'h0000_05DC;
   localparam logic [SET_W-1:0] UNRESTRAINED_DEF = 11'h320;

   // Flag bit positions in start, status, clear and enable registers
   localparam int BIT_RESTR_A = 0;
   localparam int BIT_RESTR_B = 1;
   localparam int BIT_RESTR_C = 2;
   localparam int BIT_UNRESTR_A = 3;
   localparam int BIT_UNRESTR_B = 4;
   localparam int BIT_UNRESTR_C = 5;
   localparam int BIT_UNRESTR_ANY = 6;

   function automatic logic [THR_W-1:0] max32(input logic [THR_W-1:0] a, input logic [THR_W-1:0] b);
      return (a > b) ? a : b;
   endfunction : max32

   function automatic logic [MAG_W-1:0] max16(input logic [MAG_W-1:0] a, input logic [MAG_W-1:0] b);
      return (a > b) ? a : b;
   endfunction : max16

   function automatic logic in_range(input logic [DATA_W-1:0] v, input logic [DATA_W-1:0] lo,
                                     input logic [DATA_W-1:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction : in_range

endpackage : ldce_pkg

// ---- rtl/ldce_threshold.sv ----
// Piecewise restrained characteristic threshold, scaled by one hundred
`timescale 1ns/1ps
module ldce_threshold (
   input wire logic [ldce_pkg::MAG_W-1:0] bias,
   input wire logic [ldce_pkg::SET_W-1:0] base_sensitivity_setting,
   input wire logic [ldce_pkg::SET_W-1:0] first_slope_setting,
   input wire logic [ldce_pkg::SET_W-1:0] second_slope_setting,
   input wire logic [ldce_pkg::SET_W-1:0] restraint_breakpoint_setting,
   output logic [ldce_pkg::THR_W-1:0] threshold
);

   logic [ldce_pkg::THR_W-1:0] sec_base;
   logic [ldce_pkg::THR_W-1:0] sec_first;
   logic [ldce_pkg::THR_W-1:0] sec_second;
   logic [ldce_pkg::THR_W-1:0] bias_w;
   logic [ldce_pkg::THR_W-1:0] bp_w;

   always_comb begin
      bias_w = ldce_pkg::THR_W'(bias);
      bp_w = ldce_pkg::THR_W'(restraint_breakpoint_setting);
      sec_base = ldce_pkg::THR_W'(base_sensitivity_setting) * ldce_pkg::PCT_SCALE;
      sec_first = ldce_pkg::THR_W'(first_slope_setting) * bias_w;
      // Third section continues from the first-slope value at the breakpoint
      if (bias_w > bp_w) begin
         sec_second = ldce_pkg::THR_W'(first_slope_setting) * bp_w
                    + ldce_pkg::THR_W'(second_slope_setting) * (bias_w - bp_w);
         sec_first = ldce_pkg::THR_W'(first_slope_setting) * bp_w;
      end else begin
         sec_second = '0;
      end
      threshold = ldce_pkg::max32(sec_base, ldce_pkg::max32(sec_first, sec_second));
   end

endmodule : ldce_threshold

// ---- rtl/ldce_top.sv ----
// Line differential characteristic evaluator with APB settings, status and interrupt
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
// What this block does
// - one restraint magnitude for all phases, the largest of six local/remote magnitudes.
// - per phase, restrained start while differential lies above the characteristic.
// - base sensitivity setting, 10 to 50 percent, step 1, default 30.
// - first slope setting, 10 to 50 percent, step 1, default 30.
// - second slope setting, 50 to 100 percent, step 1, default 70.
// - restraint breakpoint setting, 100 to 400 percent, step 1, default 200.
// - per phase, unrestrained start while differential exceeds the high-current setting.
// - general unrestrained start is the OR of the three phase flags.
// - unrestrained threshold setting, 500 to 1500 percent, step 1, default 800.
// - unrestrained decision ignores the restraint magnitude entirely.
module ldce_top (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ldce_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ldce_pkg::DATA_W-1:0] pwdata,
   output logic [ldce_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [ldce_pkg::MAG_W-1:0] diff_mag_phase_a,
   input wire logic [ldce_pkg::MAG_W-1:0] diff_mag_phase_b,
   input wire logic [ldce_pkg::MAG_W-1:0] diff_mag_phase_c,
   input wire logic [ldce_pkg::MAG_W-1:0] local_mag_phase_a,
   input wire logic [ldce_pkg::MAG_W-1:0] local_mag_phase_b,
   input wire logic [ldce_pkg::MAG_W-1:0] local_mag_phase_c,
   input wire logic [ldce_pkg::MAG_W-1:0] remote_mag_phase_a,
   input wire logic [ldce_pkg::MAG_W-1:0] remote_mag_phase_b,
   input wire logic [ldce_pkg::MAG_W-1:0] remote_mag_phase_c,
   output logic restrained_start_phase_a,
   output logic restrained_start_phase_b,
   output logic restrained_start_phase_c,
   output logic unrestrained_start_phase_a,
   output logic unrestrained_start_phase_b,
   output logic unrestrained_start_phase_c,
   output logic unrestrained_start_any,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Settings and software state

   logic [ldce_pkg::SET_W-1:0] base_sensitivity_setting;
   logic [ldce_pkg::SET_W-1:0] first_slope_setting;
   logic [ldce_pkg::SET_W-1:0] second_slope_setting;
   logic [ldce_pkg::SET_W-1:0] restraint_breakpoint_setting;
   logic [ldce_pkg::SET_W-1:0] unrestrained_threshold_setting;
   logic [ldce_pkg::FLAG_N:0] irq_enable;
   logic [ldce_pkg::FLAG_N:0] irq_status;
   logic [ldce_pkg::SET_W-1:0] next_base_sensitivity_setting;
   logic [ldce_pkg::SET_W-1:0] next_first_slope_setting;
   logic [ldce_pkg::SET_W-1:0] next_second_slope_setting;
   logic [ldce_pkg::SET_W-1:0] next_restraint_breakpoint_setting;
   logic [ldce_pkg::SET_W-1:0] next_unrestrained_threshold_setting;
   logic [ldce_pkg::FLAG_N:0] next_irq_enable;
   logic [ldce_pkg::FLAG_N:0] next_irq_status;
   logic next_irq;

   // Evaluation state
   logic [ldce_pkg::MAG_W-1:0] restraint_mag;
   logic [ldce_pkg::FLAG_N:0] start_flags;
   logic [ldce_pkg::MAG_W-1:0] next_restraint_mag;
   logic [ldce_pkg::FLAG_N:0] next_start_flags;
   logic [ldce_pkg::THR_W-1:0] char_threshold;
   logic [ldce_pkg::THR_W-1:0] scaled_diff_a;
   logic [ldce_pkg::THR_W-1:0] scaled_diff_b;
   logic [ldce_pkg::THR_W-1:0] scaled_diff_c;

   // Bus state
   logic [ldce_pkg::DATA_W-1:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic setup_phase;
   logic access_done;
   logic wr_commit;
   logic [ldce_pkg::FLAG_N:0] clear_bits;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Characteristic evaluation

   ldce_threshold u_threshold (
      .bias(next_restraint_mag),
      .base_sensitivity_setting(base_sensitivity_setting),
      .first_slope_setting(first_slope_setting),
      .second_slope_setting(second_slope_setting),
      .restraint_breakpoint_setting(restraint_breakpoint_setting),
      .threshold(char_threshold)
   );

   always_comb begin
      // Common restraint taken over all six shifted magnitudes
      next_restraint_mag = ldce_pkg::max16(
         ldce_pkg::max16(ldce_pkg::max16(local_mag_phase_a, remote_mag_phase_a),
                         ldce_pkg::max16(local_mag_phase_b, remote_mag_phase_b)),
         ldce_pkg::max16(local_mag_phase_c, remote_mag_phase_c));
      scaled_diff_a = ldce_pkg::THR_W'(diff_mag_phase_a) * ldce_pkg::PCT_SCALE;
      scaled_diff_b = ldce_pkg::THR_W'(diff_mag_phase_b) * ldce_pkg::PCT_SCALE;
      scaled_diff_c = ldce_pkg::THR_W'(diff_mag_phase_c) * ldce_pkg::PCT_SCALE;
      next_start_flags = '0;
      next_start_flags[ldce_pkg::BIT_RESTR_A] = scaled_diff_a > char_threshold;
      next_start_flags[ldce_pkg::BIT_RESTR_B] = scaled_diff_b > char_threshold;
      next_start_flags[ldce_pkg::BIT_RESTR_C] = scaled_diff_c > char_threshold;
      // High-current decision compares the differential alone
      next_start_flags[ldce_pkg::BIT_UNRESTR_A] =
         diff_mag_phase_a > ldce_pkg::MAG_W'(unrestrained_threshold_setting);
      next_start_flags[ldce_pkg::BIT_UNRESTR_B] =
         diff_mag_phase_b > ldce_pkg::MAG_W'(unrestrained_threshold_setting);
      next_start_flags[ldce_pkg::BIT_UNRESTR_C] =
         diff_mag_phase_c > ldce_pkg::MAG_W'(unrestrained_threshold_setting);
      next_start_flags[ldce_pkg::BIT_UNRESTR_ANY] = next_start_flags[ldce_pkg::BIT_UNRESTR_A]
                                                  | next_start_flags[ldce_pkg::BIT_UNRESTR_B]
                                                  | next_start_flags[ldce_pkg::BIT_UNRESTR_C];
   end

   // Flags follow the inputs of the previous edge, with no hold or stretch
   always_ff @(posedge clk) begin
      if (!rstn) begin
         restraint_mag <= '0;
         start_flags <= '0;
      end else begin
         restraint_mag <= next_restraint_mag;
         start_flags <= next_start_flags;
      end
   end

   assign restrained_start_phase_a = start_flags[ldce_pkg::BIT_RESTR_A];
   assign restrained_start_phase_b = start_flags[ldce_pkg::BIT_RESTR_B];
   assign restrained_start_phase_c = start_flags[ldce_pkg::BIT_RESTR_C];
   assign unrestrained_start_phase_a = start_flags[ldce_pkg::BIT_UNRESTR_A];
   assign unrestrained_start_phase_b = start_flags[ldce_pkg::BIT_UNRESTR_B];
   assign unrestrained_start_phase_c = start_flags[ldce_pkg::BIT_UNRESTR_C];
   assign unrestrained_start_any = start_flags[ldce_pkg::BIT_UNRESTR_ANY];

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Setting registers and interrupt state

   always_comb begin
      setup_phase = psel & ~penable;
      access_done = psel & penable & pready;
      wr_commit = access_done & pwrite & ~pslverr;
      next_base_sensitivity_setting = base_sensitivity_setting;
      next_first_slope_setting = first_slope_setting;
      next_second_slope_setting = second_slope_setting;
      next_restraint_breakpoint_setting = restraint_breakpoint_setting;
      next_unrestrained_threshold_setting = unrestrained_threshold_setting;
      next_irq_enable = irq_enable;
      clear_bits = '0;
      if (wr_commit) begin
         unique case (paddr)
            ldce_pkg::OFS_BASE: begin
               next_base_sensitivity_setting = pwdata[ldce_pkg::SET_W-1:0];
            end
            ldce_pkg::OFS_SLOPE1: begin
               next_first_slope_setting = pwdata[ldce_pkg::SET_W-1:0];
            end
            ldce_pkg::OFS_SLOPE2: begin
               next_second_slope_setting = pwdata[ldce_pkg::SET_W-1:0];
            end
            ldce_pkg::OFS_BREAKPOINT: begin
               next_restraint_breakpoint_setting = pwdata[ldce_pkg::SET_W-1:0];
            end
            ldce_pkg::OFS_UNRESTRAINED: begin
               next_unrestrained_threshold_setting = pwdata[ldce_pkg::SET_W-1:0];
            end
            ldce_pkg::OFS_ENABLE: begin
               next_irq_enable = pwdata[ldce_pkg::FLAG_N:0];
            end
            ldce_pkg::OFS_CLEAR: begin
               clear_bits = pwdata[ldce_pkg::FLAG_N:0];
            end
            default: begin
            end
         endcase
      end
      // Rising edges of the start flags are latched; a new edge beats a clear
      next_irq_status = (irq_status & ~clear_bits) | (next_start_flags & ~start_flags);
      next_irq = |(next_irq_status & next_irq_enable);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         base_sensitivity_setting <= ldce_pkg::BASE_DEF;
         first_slope_setting <= ldce_pkg::SLOPE1_DEF;
         second_slope_setting <= ldce_pkg::SLOPE2_DEF;
         restraint_breakpoint_setting <= ldce_pkg::BREAKPOINT_DEF;
         unrestrained_threshold_setting <= ldce_pkg::UNRESTRAINED_DEF;
         irq_enable <= '0;
         irq_status <= '0;
         irq <= 1'b0;
      end else begin
         base_sensitivity_setting <= next_base_sensitivity_setting;
         first_slope_setting <= next_first_slope_setting;
         second_slope_setting <= next_second_slope_setting;
         restraint_breakpoint_setting <= next_restraint_breakpoint_setting;
         unrestrained_threshold_setting <= next_unrestrained_threshold_setting;
         irq_enable <= next_irq_enable;
         irq_status <= next_irq_status;
         irq <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // APB answer: decoded in the setup cycle, ready in the single access cycle

   always_comb begin
      next_pready = setup_phase;
      next_pslverr = 1'b0;
      next_prdata = '0;
      if (setup_phase) begin
         unique case (paddr)
            ldce_pkg::OFS_BASE: begin
               next_prdata = ldce_pkg::DATA_W'(base_sensitivity_setting);
               next_pslverr = pwrite & ~ldce_pkg::in_range(pwdata, ldce_pkg::BASE_MIN,
                                                           ldce_pkg::BASE_MAX);
            end
            ldce_pkg::OFS_SLOPE1: begin
               next_prdata = ldce_pkg::DATA_W'(first_slope_setting);
               next_pslverr = pwrite & ~ldce_pkg::in_range(pwdata, ldce_pkg::SLOPE1_MIN,
                                                           ldce_pkg::SLOPE1_MAX);
            end
            ldce_pkg::OFS_SLOPE2: begin
               next_prdata = ldce_pkg::DATA_W'(second_slope_setting);
               next_pslverr = pwrite & ~ldce_pkg::in_range(pwdata, ldce_pkg::SLOPE2_MIN,
                                                           ldce_pkg::SLOPE2_MAX);
            end
            ldce_pkg::OFS_BREAKPOINT: begin
               next_prdata = ldce_pkg::DATA_W'(restraint_breakpoint_setting);
               next_pslverr = pwrite & ~ldce_pkg::in_range(pwdata, ldce_pkg::BREAKPOINT_MIN,
                                                           ldce_pkg::BREAKPOINT_MAX);
            end
            ldce_pkg::OFS_UNRESTRAINED: begin
               next_prdata = ldce_pkg::DATA_W'(unrestrained_threshold_setting);
               next_pslverr = pwrite & ~ldce_pkg::in_range(pwdata, ldce_pkg::UNRESTRAINED_MIN,
                                                           ldce_pkg::UNRESTRAINED_MAX);
            end
            ldce_pkg::OFS_START: begin
               next_prdata = ldce_pkg::DATA_W'(start_flags);
               next_pslverr = pwrite;
            end
            ldce_pkg::OFS_STATUS: begin
               next_prdata = ldce_pkg::DATA_W'(irq_status);
               next_pslverr = pwrite;
            end
            ldce_pkg::OFS_CLEAR: begin
               next_pslverr = ~pwrite;
            end
            ldce_pkg::OFS_ENABLE: begin
               next_prdata = ldce_pkg::DATA_W'(irq_enable);
            end
            ldce_pkg::OFS_BIAS: begin
               next_prdata = ldce_pkg::DATA_W'(restraint_mag);
               next_pslverr = pwrite;
            end
            default: begin
               next_pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

endmodule : ldce_top

// ---- tb/ldce_mag_src.sv ----
// Upstream magnitude source model feeding the evaluator
`timescale 1ns/1ps
module ldce_mag_src (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ld,
   input wire logic [8:0][15:0] vals,
   output logic [8:0][15:0] mags
);
   logic [8:0][15:0] next_mags;
   // A new set appears only when loaded, and reset clears it to zero; otherwise it holds like a finished calculation
   always_comb begin
      next_mags = ld ? vals : mags;
      if (!rstn) begin
         next_mags = '0;
      end
   end
   always_ff @(posedge clk) begin
      mags <= next_mags;
   end
endmodule : ldce_mag_src

// ---- tb/ldce_chk_sva.sv ----
// Port-level assertions of the characteristic evaluator
`timescale 1ns/1ps
module ldce_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] diff_mag_phase_a,
   input wire logic [15:0] local_mag_phase_a,
   input wire logic [15:0] local_mag_phase_b,
   input wire logic [15:0] local_mag_phase_c,
   input wire logic [15:0] remote_mag_phase_a,
   input wire logic [15:0] remote_mag_phase_b,
   input wire logic [15:0] remote_mag_phase_c,
   input wire logic restrained_start_phase_a,
   input wire logic unrestrained_start_phase_a,
   input wire logic unrestrained_start_phase_b,
   input wire logic unrestrained_start_phase_c,
   input wire logic unrestrained_start_any,
   input wire logic irq
);
   logic [15:0] bias;
   logic [15:0] m1;
   logic [15:0] m2;
   always_comb begin
      m1 = (local_mag_phase_a > local_mag_phase_b) ? local_mag_phase_a : local_mag_phase_b;
      m1 = (local_mag_phase_c > m1) ? local_mag_phase_c : m1;
      m2 = (remote_mag_phase_a > remote_mag_phase_b) ? remote_mag_phase_a : remote_mag_phase_b;
      m2 = (remote_mag_phase_c > m2) ? remote_mag_phase_c : m2;
      bias = (m1 > m2) ? m1 : m2;
   end
   default clocking cb @(posedge clk); endclocking
   ////////////////////////////////////////////////////////////////////////
   chk_ready_next: assert property (disable iff (!rstn) psel && !penable |=> pready)
      else $error("pready missing after setup");
   chk_ready_pulse: assert property (disable iff (!rstn) pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_ready_cause: assert property (disable iff (!rstn) pready |-> $past(psel && !penable))
      else $error("pready without setup");
   chk_rdata_idle: assert property (disable iff (!rstn) !pready |-> prdata == 32'h0000_0000)
      else $error("prdata not zero outside access");
   chk_err_access: assert property (disable iff (!rstn) pslverr |-> pready)
      else $error("pslverr outside access");
   ////////////////////////////////////////////////////////////////////////
   // Above 1500 every legal setting is exceeded, whatever the bias
   chk_unr_high: assert property (disable iff (!rstn)
      $past(rstn) && $past(diff_mag_phase_a) > 1500 |-> unrestrained_start_phase_a)
      else $error("unrestrained start missing");
   chk_unr_low: assert property (disable iff (!rstn)
      unrestrained_start_phase_a |-> $past(diff_mag_phase_a) > 500)
      else $error("unrestrained start too low");
   chk_any_or: assert property (disable iff (!rstn) unrestrained_start_any ==
      (unrestrained_start_phase_a | unrestrained_start_phase_b | unrestrained_start_phase_c))
      else $error("general start not the OR");
   // Threshold never exceeds 100 times max(bias, 50)
   chk_res_high: assert property (disable iff (!rstn) $past(rstn) &&
      $past(diff_mag_phase_a) > 50 && $past(diff_mag_phase_a) > $past(bias) |-> restrained_start_phase_a)
      else $error("restrained start missing");
   chk_res_low: assert property (disable iff (!rstn)
      restrained_start_phase_a |-> $past(diff_mag_phase_a) > 10)
      else $error("restrained start below base");
   cover property (disable iff (!rstn) unrestrained_start_phase_a);
   cover property (disable iff (!rstn) restrained_start_phase_a);
   cover property (disable iff (!rstn) pslverr);
   cover property (disable iff (!rstn) irq);
endmodule : ldce_chk
bind ldce_top ldce_chk u_ldce_chk (.clk, .rstn, .psel, .penable, .prdata, .pready, .pslverr, .diff_mag_phase_a,
   .local_mag_phase_a, .local_mag_phase_b, .local_mag_phase_c, .remote_mag_phase_a, .remote_mag_phase_b,
   .remote_mag_phase_c, .restrained_start_phase_a, .unrestrained_start_phase_a, .unrestrained_start_phase_b,
   .unrestrained_start_phase_c, .unrestrained_start_any, .irq);

// ---- tb/ldce_top_tb.sv ----
// Self-checking bench of the characteristic evaluator
`timescale 1ns/1ps
module ldce_top_tb;
   typedef struct {logic [15:0] d0, d1, d2, bv; int bi; logic [6:0] f;} ldce_row_t;
   logic clk, rstn, psel, penable, pwrite, ld, pready, pslverr, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [8:0][15:0] vals, mags, v;
   logic [6:0] flags;
   int mismatches, checks_done;
   ldce_row_t rows [4];
   logic [31:0] offs [5] = '{32'h00, 32'h04, 32'h08, 32'h0C, 32'h10};
   logic [31:0] defs [5] = '{32'h1E, 32'h1E, 32'h46, 32'hC8, 32'h320};
   logic [31:0] mins [5] = '{32'h0A, 32'h0A, 32'h32, 32'h64, 32'h1F4};
   logic [31:0] maxs [5] = '{32'h32, 32'h32, 32'h64, 32'h190, 32'h5DC};
   logic [31:0] bad [5] = '{32'h14, 32'h18, 32'h24, 32'h1C, 32'h28};
   ldce_top u_ldce_top (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .diff_mag_phase_a(mags[0]),
      .diff_mag_phase_b(mags[1]), .diff_mag_phase_c(mags[2]), .local_mag_phase_a(mags[3]),
      .local_mag_phase_b(mags[4]), .local_mag_phase_c(mags[5]), .remote_mag_phase_a(mags[6]),
      .remote_mag_phase_b(mags[7]), .remote_mag_phase_c(mags[8]), .restrained_start_phase_a(flags[0]),
      .restrained_start_phase_b(flags[1]), .restrained_start_phase_c(flags[2]),
      .unrestrained_start_phase_a(flags[3]), .unrestrained_start_phase_b(flags[4]),
      .unrestrained_start_phase_c(flags[5]), .unrestrained_start_any(flags[6]), .irq(irq));
   ldce_mag_src u_ldce_mag_src (.clk(clk), .rstn(rstn), .ld(ld), .vals(vals), .mags(mags));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
         mismatches++;
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a[11:0];
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic set_mags(input logic [8:0][15:0] m);
      @(posedge clk);
      vals <= m;
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
   endtask : set_mags
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      close_out();
   end
   initial begin
      {rstn, psel, penable, pwrite, ld, paddr, pwdata, vals} = '0;
      rows[0] = '{16'h001E, 16'h001F, 16'h0000, 16'h0032, 0, 7'h02};
      rows[1] = '{16'h003C, 16'h003D, 16'h0321, 16'h00C8, 4, 7'h66};
      rows[2] = '{16'h0082, 16'h0083, 16'h0320, 16'h012C, 2, 7'h06};
      rows[3] = '{16'h05DD, 16'h026D, 16'h026C, 16'h03E8, 5, 7'h4B};
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, offs[i], 32'h0);
         chk("default", defs[i], rd);
         apb(1'b1, offs[i], mins[i] - 1);
         chk("below min", 32'h1, {31'h0, err});
         apb(1'b1, offs[i], maxs[i]);
         chk("max taken", 32'h0, {31'h0, err});
         apb(1'b1, offs[i], maxs[i] + 1);
         apb(0, offs[i], 32'h0);
         chk("max kept", maxs[i], rd);
         apb(1'b1, offs[i], defs[i]);
         apb(1'b1, bad[i], 32'h7F);
         chk("write refused", {31'h0, bad[i] != 32'h1C}, {31'h0, err});
         apb(1'b0, bad[i], 32'h0);
         chk("read refused", {31'h0, bad[i] == 32'h1C || bad[i] == 32'h28}, {31'h0, err});
      end
      $display("test settings done");
      foreach (rows[i]) begin
         v = {{6{16'h0001}}, rows[i].d2, rows[i].d1, rows[i].d0};
         v[3 + rows[i].bi] = rows[i].bv;
         set_mags(v);
         apb(1'b0, 32'h24, 32'h0);
         chk("bias", {16'h0, rows[i].bv}, rd);
         chk("flags", {25'h0, rows[i].f}, {25'h0, flags});
      end
      $display("test table done");
      apb(1'b1, 32'h10, 32'h1F4);
      set_mags({16'h03E8, {5{16'h0001}}, 16'h0, 16'h0, 16'h01F5});
      apb(1'b0, 32'h14, 32'h0);
      chk("low setting", 32'h48, rd);
      set_mags({16'h03E8, {5{16'h0001}}, 16'h0, 16'h0, 16'h01F4});
      apb(1'b0, 32'h14, 32'h0);
      chk("at setting", 32'h0, rd);
      $display("test unrestrained done");
      set_mags('0);
      apb(1'b1, 32'h1C, 32'h7F);
      apb(1'b1, 32'h20, 32'h08);
      apb(1'b0, 32'h18, 32'h0);
      chk("status clear", 32'h0, rd);
      chk("irq idle", 32'h0, {31'h0, irq});
      set_mags(144'h0384);
      apb(1'b0, 32'h18, 32'h0);
      chk("status set", 32'h49, rd);
      set_mags('0);
      apb(1'b0, 32'h14, 32'h0);
      chk("flags drop", 32'h0, rd);
      chk("irq sticky", 32'h1, {31'h0, irq});
      apb(1'b1, 32'h20, 32'h0);
      apb(1'b0, 32'h20, 32'h0);
      chk("enable read", 32'h0, rd);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, 32'h20, 32'h08);
      apb(1'b0, 32'h20, 32'h0);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      apb(1'b1, 32'h1C, 32'h08);
      apb(1'b0, 32'h18, 32'h0);
      chk("status after clear", 32'h41, rd);
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test interrupt done");
      apb(1'b1, 32'h10, 32'h5DC);
      set_mags(144'h0384);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      chk("flags in reset", 32'h0, {25'h0, flags});
      rstn <= 1'b1;
      // The upstream source clears with the block, so the set is loaded again
      set_mags(144'h0384);
      apb(1'b0, 32'h10, 32'h0);
      chk("setting reset", 32'h320, rd);
      chk("flags after reset", 32'h49, {25'h0, flags});
      $display("test reset done");
      close_out();
   end
endmodule : ldce_top_tb
